/* File: hw/rdp_pkg.sv */
// Purpose: Shared constants for the regulator discharge and power-good register slice
// Assumes: 250 MHz system clock; byte-wide registers behind a two-wire serial port
// Notes: Times are in microseconds; cycle counts are derived from the clock rate
package rdp_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] RDP_OFS_RAIL6_CONTROL = 8'h27;
    localparam logic [7:0] RDP_OFS_DISCH_FIRST = 8'h40;
    localparam logic [7:0] RDP_OFS_DISCH_SECOND = 8'h41;
    localparam logic [7:0] RDP_OFS_DISCH_THIRD = 8'h42;
    localparam logic [7:0] RDP_OFS_PGOOD_DELAY = 8'h43;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RDP_RST_RAIL6_CONTROL = 8'h3D;
    localparam logic [7:0] RDP_RST_DISCH_FIRST = 8'h55;
    localparam logic [7:0] RDP_RST_DISCH_SECOND = 8'h55;
    localparam logic [7:0] RDP_RST_DISCH_THIRD = 8'h05;
    localparam logic [7:0] RDP_RST_PGOOD_DELAY = 8'h07;
    localparam int RDP_MODE_BIT = 1;
    localparam int RDP_NUM_RAILS = 10;

    // ----------------------------------------------------------------
    // Discharge codes and delay codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RDP_DIS_NONE = 2'h0;
    localparam logic [2:0] RDP_DLY_2P5 = 3'h0;
    localparam logic [2:0] RDP_DLY_5 = 3'h1;
    localparam logic [2:0] RDP_DLY_10 = 3'h2;
    localparam logic [2:0] RDP_DLY_15 = 3'h3;
    localparam logic [2:0] RDP_DLY_20 = 3'h4;
    localparam logic [2:0] RDP_DLY_50 = 3'h5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int RDP_CLK_MHZ = 250;
    localparam int RDP_T_2P5_US = 2500;
    localparam int RDP_T_5_US = 5000;
    localparam int RDP_T_10_US = 10000;
    localparam int RDP_T_15_US = 15000;
    localparam int RDP_T_20_US = 20000;
    localparam int RDP_T_50_US = 50000;
    localparam int RDP_T_100_US = 100000;
    localparam int RDP_CYC_2P5 = RDP_T_2P5_US * RDP_CLK_MHZ;
    localparam int RDP_CYC_5 = RDP_T_5_US * RDP_CLK_MHZ;
    localparam int RDP_CYC_10 = RDP_T_10_US * RDP_CLK_MHZ;
    localparam int RDP_CYC_15 = RDP_T_15_US * RDP_CLK_MHZ;
    localparam int RDP_CYC_20 = RDP_T_20_US * RDP_CLK_MHZ;
    localparam int RDP_CYC_50 = RDP_T_50_US * RDP_CLK_MHZ;
    localparam int RDP_CYC_100 = RDP_T_100_US * RDP_CLK_MHZ;

    // Serial port: device address (arbitrary neutral value) and bit count
    localparam logic [6:0] RDP_DEV_ADDR = 7'h2A;
    localparam logic [3:0] RDP_BITS_BYTE = 4'h8;
    localparam logic [3:0] RDP_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        RDP_ST_IDLE,
        RDP_ST_ADDR,
        RDP_ST_ADDR_ACK,
        RDP_ST_WR_BYTE,
        RDP_ST_WR_ACK,
        RDP_ST_RD_BYTE,
        RDP_ST_RD_ACK
    } rdp_state_t;

endpackage

/* File: hw/rdp_regs.sv */
// Purpose: Rail-6 mode, discharge selects and power-good delay registers behind a serial port
// Assumes: Rail enables and the all-in-regulation level come from logic on clk_in
// Notes: Serial clock and data are pins and pass a three-stage filter before use
`timescale 1ns/1ps
module rdp_regs import rdp_pkg::*; #(
    parameter int CYC_2P5 = RDP_CYC_2P5,
    parameter int CYC_5 = RDP_CYC_5,
    parameter int CYC_10 = RDP_CYC_10,
    parameter int CYC_15 = RDP_CYC_15,
    parameter int CYC_20 = RDP_CYC_20,
    parameter int CYC_50 = RDP_CYC_50,
    parameter int CYC_100 = RDP_CYC_100
) (
    input wire logic clk_in, // System clock, 250 MHz
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe_n_out, // Low while pulling data low
    input wire logic [9:0] rail_enable_in, // Per-rail enable from sequencer
    input wire logic all_in_reg_in, // All enabled rails in regulation
    output logic rail6_op_mode_sel_out, // Rail-6 forced PWM when high
    output logic [19:0] discharge_load_out, // Applied discharge code per rail
    output logic platform_power_good_out // Delayed platform power good
);

    // ----------------------------------------------------------------
    // Pin filter: three stages, change taken when stages two and three agree
    // ----------------------------------------------------------------
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f;
    logic sda_f;
    logic scl_prev;
    logic sda_prev;

    // Synchronise and filter the serial pins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            if (scl_sync[1] == scl_sync[2]) begin
                scl_f <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_f <= sda_sync[2];
            end
            scl_prev <= scl_f;
            sda_prev <= sda_f;
        end
    end

    // Bus events
    wire scl_rise = scl_f && !scl_prev;
    wire scl_fall = !scl_f && scl_prev;
    wire bus_start = scl_f && scl_prev && sda_prev && !sda_f;
    wire bus_stop = scl_f && scl_prev && !sda_prev && sda_f;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [5:0] rail6_ctrl;
    logic [19:0] dis_sel;
    logic [1:0] third_hi;
    logic [2:0] pgood_delay_sel;
    logic [7:0] ptr;

    // Read data for one offset; unmapped offsets read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] ofs);
        logic [7:0] v;
        v = 8'h00;
        unique case (ofs)
            RDP_OFS_RAIL6_CONTROL: v = {2'h0, rail6_ctrl};
            RDP_OFS_DISCH_FIRST: v = dis_sel[7:0];
            RDP_OFS_DISCH_SECOND: v = dis_sel[15:8];
            RDP_OFS_DISCH_THIRD: v = {2'h0, third_hi, dis_sel[19:16]};
            RDP_OFS_PGOOD_DELAY: v = {5'h00, pgood_delay_sel};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Serial slave state
    // ----------------------------------------------------------------
    rdp_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic have_ptr;

    // Write strobe and offset decode
    wire byte_done = scl_fall && (bit_cnt == RDP_BITS_BYTE);
    wire wr_stb = byte_done && (st == RDP_ST_WR_BYTE) && have_ptr;
    wire wr_r6 = wr_stb && (ptr == RDP_OFS_RAIL6_CONTROL);
    wire wr_d1 = wr_stb && (ptr == RDP_OFS_DISCH_FIRST);
    wire wr_d2 = wr_stb && (ptr == RDP_OFS_DISCH_SECOND);
    wire wr_d3 = wr_stb && (ptr == RDP_OFS_DISCH_THIRD);
    wire wr_dl = wr_stb && (ptr == RDP_OFS_PGOOD_DELAY);
    wire [7:0] ptr_inc = ptr + 8'h01;

    // Byte-level protocol engine
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= RDP_ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            have_ptr <= 1'b0;
            ptr <= 8'h00;
            sda_oe_n_out <= 1'b1;
        end else if (bus_start) begin
            st <= RDP_ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe_n_out <= 1'b1;
        end else if (bus_stop) begin
            st <= RDP_ST_IDLE;
            sda_oe_n_out <= 1'b1;
        end else if (scl_rise) begin
            if (st == RDP_ST_ADDR || st == RDP_ST_WR_BYTE) begin
                shreg <= {shreg[6:0], sda_f};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (st == RDP_ST_RD_ACK && sda_f) begin
                st <= RDP_ST_IDLE; // Master declined more data
            end
        end else if (scl_fall) begin
            unique case (st)
                RDP_ST_IDLE: begin
                    sda_oe_n_out <= 1'b1;
                end
                RDP_ST_ADDR: begin
                    if (bit_cnt == RDP_BITS_BYTE) begin
                        if (shreg[7:1] == RDP_DEV_ADDR) begin
                            st <= RDP_ST_ADDR_ACK;
                            rw <= shreg[0];
                            sda_oe_n_out <= 1'b0;
                        end else begin
                            st <= RDP_ST_IDLE;
                        end
                    end
                end
                RDP_ST_ADDR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (rw) begin
                        st <= RDP_ST_RD_BYTE;
                        shreg <= rd_mux(ptr);
                        sda_oe_n_out <= 1'(rd_mux(ptr) >> 7); // MSB first
                    end else begin
                        st <= RDP_ST_WR_BYTE;
                        have_ptr <= 1'b0;
                        sda_oe_n_out <= 1'b1;
                    end
                end
                RDP_ST_WR_BYTE: begin
                    if (bit_cnt == RDP_BITS_BYTE) begin
                        st <= RDP_ST_WR_ACK;
                        sda_oe_n_out <= 1'b0;
                        have_ptr <= 1'b1;
                        ptr <= have_ptr ? ptr_inc : shreg;
                    end
                end
                RDP_ST_WR_ACK: begin
                    st <= RDP_ST_WR_BYTE;
                    bit_cnt <= 4'h0;
                    sda_oe_n_out <= 1'b1;
                end
                RDP_ST_RD_BYTE: begin
                    if (bit_cnt == RDP_LAST_BIT) begin
                        st <= RDP_ST_RD_ACK;
                        sda_oe_n_out <= 1'b1;
                    end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe_n_out <= shreg[6];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                RDP_ST_RD_ACK: begin
                    st <= RDP_ST_RD_BYTE;
                    bit_cnt <= 4'h0;
                    ptr <= ptr_inc;
                    shreg <= rd_mux(ptr_inc);
                    sda_oe_n_out <= 1'(rd_mux(ptr_inc) >> 7); // MSB first
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [19:0] wr_dis;
    logic [19:0] next_dis_sel;

    // Discharge fields: software write, then enable clears to 00
    always_comb begin
        wr_dis = dis_sel;
        if (wr_d1) begin
            wr_dis[7:0] = shreg;
        end
        if (wr_d2) begin
            wr_dis[15:8] = shreg;
        end
        if (wr_d3) begin
            wr_dis[19:16] = shreg[3:0];
        end
        next_dis_sel = wr_dis;
        for (int i = 0; i < RDP_NUM_RAILS; i++) begin
            if (rail_enable_in[i]) begin
                next_dis_sel[2*i +: 2] = RDP_DIS_NONE;
            end
        end
    end

    // Register update
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rail6_ctrl <= RDP_RST_RAIL6_CONTROL[5:0];
            dis_sel <= {RDP_RST_DISCH_THIRD[3:0], RDP_RST_DISCH_SECOND,
                RDP_RST_DISCH_FIRST};
            third_hi <= RDP_RST_DISCH_THIRD[5:4];
            pgood_delay_sel <= RDP_RST_PGOOD_DELAY[2:0];
        end else begin
            dis_sel <= next_dis_sel;
            if (wr_r6) begin
                rail6_ctrl <= shreg[5:0];
            end
            if (wr_d3) begin
                third_hi <= shreg[5:4];
            end
            if (wr_dl) begin
                pgood_delay_sel <= shreg[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Power-good delay
    // ----------------------------------------------------------------
    logic [31:0] dly_target;
    logic [31:0] pg_cnt;

    // Delay code to cycle count; unlisted code falls to the longest
    always_comb begin
        unique case (pgood_delay_sel)
            RDP_DLY_2P5: dly_target = 32'(CYC_2P5);
            RDP_DLY_5: dly_target = 32'(CYC_5);
            RDP_DLY_10: dly_target = 32'(CYC_10);
            RDP_DLY_15: dly_target = 32'(CYC_15);
            RDP_DLY_20: dly_target = 32'(CYC_20);
            RDP_DLY_50: dly_target = 32'(CYC_50);
            default: dly_target = 32'(CYC_100);
        endcase
    end

    // Count from regulation; drop at once when regulation is lost
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !all_in_reg_in) begin
            pg_cnt <= 32'h0000_0000;
            platform_power_good_out <= 1'b0;
        end else begin
            if (!platform_power_good_out) begin
                pg_cnt <= pg_cnt + 32'h0000_0001;
            end
            platform_power_good_out <= (pg_cnt + 32'h0000_0001 >= dly_target);
        end
    end

    // ----------------------------------------------------------------
    // Outputs to the regulators
    // ----------------------------------------------------------------
    logic [19:0] next_load;

    // Load only while rail off
    always_comb begin
        next_load = dis_sel;
        for (int i = 0; i < RDP_NUM_RAILS; i++) begin
            if (rail_enable_in[i]) begin
                next_load[2*i +: 2] = RDP_DIS_NONE;
            end
        end
    end

    // Registered drive to the analog side
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            discharge_load_out <= 20'h00000;
            rail6_op_mode_sel_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            discharge_load_out <= next_load;
            rail6_op_mode_sel_out <= rail6_ctrl[RDP_MODE_BIT];
            sda_out <= 1'b0;
        end
    end

endmodule

/* File: tb/rdp_host_model.sv */
// Purpose: Two-wire host that writes and reads the register slice
// Assumes: Half bit period of 20 system clocks
// Notes: Data released for acknowledge and read bits
`timescale 1ns/1ps
module rdp_host_model import rdp_pkg::*; (
    input wire logic clk_in, // System clock
    input wire logic sda_in, // Resolved data wire
    output logic scl_out, // Serial clock drive
    output logic sda_rel_out // High releases data
);
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    task automatic half();
        repeat (20) @(posedge clk_in);
    endtask
    // One bit: data set while clock low, sampled at end of high phase
    task automatic xfer(input logic b, output logic r);
        sda_rel_out <= b;
        half();
        scl_out <= 1'b1;
        half();
        r = sda_in;
        scl_out <= 1'b0;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic start();
        sda_rel_out <= 1'b1;
        half();
        scl_out <= 1'b1;
        half();
        sda_rel_out <= 1'b0;
        half();
        scl_out <= 1'b0;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic stop();
        sda_rel_out <= 1'b0;
        half();
        scl_out <= 1'b1;
        half();
        sda_rel_out <= 1'b1;
        half();
    endtask
    task automatic put_byte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) xfer(v[i], a);
        xfer(1'b1, a);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
        start();
        put_byte({RDP_DEV_ADDR, 1'b0});
        put_byte(ofs);
        put_byte(v);
        stop();
    endtask
    // Pointer write, repeated start, one byte read then no acknowledge
    task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
        logic a;
        start();
        put_byte({RDP_DEV_ADDR, 1'b0});
        put_byte(ofs);
        start();
        put_byte({RDP_DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) xfer(1'b1, v[i]);
        xfer(1'b1, a);
        stop();
    endtask
endmodule

/* File: tb/rdp_regs_asserts.sv */
// Purpose: Port checks for the discharge and power-good register slice
// Assumes: Delay bounds follow the design's own count parameters
// Notes: Bound to every rdp_regs instance
`timescale 1ns/1ps
module rdp_regs_asserts import rdp_pkg::*; #(
    parameter int CYC_2P5 = RDP_CYC_2P5,
    parameter int CYC_100 = RDP_CYC_100
) (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_oe_n_out, // Data pull enable
    input wire logic [9:0] rail_enable_in, // Rail enables
    input wire logic all_in_reg_in, // All rails in regulation
    input wire logic rail6_op_mode_sel_out, // Rail-6 mode
    input wire logic [19:0] discharge_load_out, // Applied discharge
    input wire logic platform_power_good_out // Power good
);
    localparam int LO = CYC_2P5 * 9 / 10 - 2;
    localparam int HI = CYC_100 * 11 / 10 + 2;
    int wait_cnt;
    logic [19:0] en_mask;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Enables widened to two-bit field masks
    always_comb for (int i = 0; i < 10; i++) en_mask[2*i+:2] = {2{rail_enable_in[i]}};
    // Cycles spent in regulation, saturating
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !all_in_reg_in) begin
            wait_cnt <= 0;
        end else if (wait_cnt < HI + 4) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    property p_en_clear; rst_n_in |=> (discharge_load_out & $past(en_mask)) == 20'h0; endproperty
    property p_pg_drop; !all_in_reg_in |=> !platform_power_good_out; endproperty
    property p_pg_min; platform_power_good_out |-> wait_cnt >= LO; endproperty
    property p_pg_max; wait_cnt > HI |-> platform_power_good_out; endproperty
    property p_pg_cause; $rose(platform_power_good_out) |-> $past(all_in_reg_in, 8); endproperty
    property p_oe_quiet; scl_in [*6] |-> $stable(sda_oe_n_out); endproperty
    property p_mode_when; $changed(rail6_op_mode_sel_out) |-> !scl_in; endproperty
    property p_dis_hold;
        (scl_in && $stable(rail_enable_in)) [*6] |=> $stable(discharge_load_out);
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("load on enabled rail");
    a_pg_drop: assert property (p_pg_drop) else $error("power good kept");
    a_pg_min: assert property (p_pg_min) else $error("power good early");
    a_pg_max: assert property (p_pg_max) else $error("power good late");
    a_pg_cause: assert property (p_pg_cause) else $error("power good uncaused");
    a_oe_quiet: assert property (p_oe_quiet) else $error("data drive moved");
    a_mode_when: assert property (p_mode_when) else $error("mode moved");
    a_dis_hold: assert property (p_dis_hold) else $error("load moved");
    c_pg: cover property ($rose(platform_power_good_out));
    c_mode: cover property ($rose(rail6_op_mode_sel_out));
    c_clear: cover property ($past(en_mask) != 20'h0 && discharge_load_out != 20'h0);
endmodule
bind rdp_regs rdp_regs_asserts #(.CYC_2P5(CYC_2P5), .CYC_100(CYC_100)) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
    .rail_enable_in(rail_enable_in), .all_in_reg_in(all_in_reg_in),
    .rail6_op_mode_sel_out(rail6_op_mode_sel_out), .discharge_load_out(discharge_load_out),
    .platform_power_good_out(platform_power_good_out));

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the discharge and power-good register slice
// Assumes: Shortened delay counts; host model drives the serial port
// Notes: A masked register model predicts register reads and the mode and discharge outputs
`timescale 1ns/1ps
module tb_top;
    import rdp_pkg::*;
    localparam int DLY [8] = '{10, 20, 40, 60, 80, 200, 400, 400};
    logic [7:0] ofs [5] = '{8'h27, 8'h40, 8'h41, 8'h42, 8'h43};
    logic [7:0] msk [5] = '{8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'h07};
    logic [7:0] rv [5] = '{8'h3D, 8'h55, 8'h55, 8'h05, 8'h07};
    logic clk_in;
    logic rst_n_in;
    logic all_in_reg_in;
    logic [9:0] rail_enable_in;
    logic scl, sda_rel, sda_out, sda_oe_n, mode, pgood;
    logic [19:0] dis;
    logic [7:0] d;
    int fail_count = 0;
    int n_compared = 0;
    int n;
    logic in_band;
    wire sda_w = sda_rel & (sda_oe_n | sda_out);

    rdp_regs #(.CYC_2P5(DLY[0]), .CYC_5(DLY[1]), .CYC_10(DLY[2]), .CYC_15(DLY[3]),
        .CYC_20(DLY[4]), .CYC_50(DLY[5]), .CYC_100(DLY[6])) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .rail_enable_in(rail_enable_in),
        .all_in_reg_in(all_in_reg_in), .rail6_op_mode_sel_out(mode),
        .discharge_load_out(dis), .platform_power_good_out(pgood));
    rdp_host_model u_host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_rel_out(sda_rel));

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Discharge fields of the model, rail 1 at the bottom
    function automatic logic [19:0] flat();
        return {rv[3][3:0], rv[2], rv[1]};
    endfunction
    // Model clears the fields of enabled rails
    task automatic clear_en();
        logic [19:0] m;
        for (int i = 0; i < 10; i++) m[2*i+:2] = {2{rail_enable_in[i]}};
        {rv[3][3:0], rv[2], rv[1]} = flat() & ~m;
    endtask
    task automatic wr_chk(input int k, input logic [7:0] v);
        u_host.wr(ofs[k], v);
        rv[k] = v & msk[k];
        clear_en();
        u_host.rd(ofs[k], d);
        check(d, rv[k]);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Watchdog: the tests need about 89000 cycles
    initial begin
        repeat (90000) @(posedge clk_in);
        fail_count++;
        summarize();
    end
    initial begin
        rst_n_in = 1'b0;
        rail_enable_in = 10'h000;
        all_in_reg_in = 1'b0;
        void'($urandom(32'h91fd9cfd));
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        // Reset values, an unmapped offset, outputs with rails off
        for (int k = 0; k < 5; k++) begin
            u_host.rd(ofs[k], d);
            check(d, rv[k]);
        end
        u_host.wr(8'h44, 8'hFF);
        u_host.rd(8'h44, d);
        check(d, 8'h00);
        check(mode, rv[0][1]);
        check(dis, flat());
        // All-ones then random writes with read-back
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) wr_chk(k, p == 0 ? 8'hFF : 8'($urandom));
            check(mode, rv[0][1]);
            check(dis, flat());
        end
        // Enabled rails lose their fields and refuse new ones
        for (int k = 1; k < 4; k++) wr_chk(k, 8'hFF);
        rail_enable_in <= 10'($urandom) | 10'h021;
        repeat (2) @(posedge clk_in);
        clear_en();
        check(dis, flat());
        for (int k = 1; k < 4; k++) wr_chk(k, 8'hFF);
        rail_enable_in <= 10'h000;
        repeat (2) @(posedge clk_in);
        check(dis, flat());
        // Each delay code, timed from regulation to power good
        for (int c = 0; c < 8; c++) begin
            wr_chk(4, 8'(c));
            all_in_reg_in <= 1'b1;
            n = 0;
            while (pgood !== 1'b1 && n < 1000) begin
                @(negedge clk_in);
                n++;
            end
            in_band = n * 10 >= DLY[c] * 9 && n * 10 <= DLY[c] * 11 + 20;
            check(in_band, 1'b1);
            @(posedge clk_in);
            all_in_reg_in <= 1'b0;
            repeat (2) @(posedge clk_in);
            check(pgood, 1'b0);
        end
        summarize();
    end
endmodule
